/* rtl/rid_pkg.sv */
// Package for the 14-bit instruction decoder: field layout, opcodes, types.
// Assumes a single 200 MHz core clock; no software registers.
package rid_pkg;
	// Field positions
	localparam int unsigned OP_HI = 13;
	localparam int unsigned DEST_BIT = 7;
	localparam int unsigned FILE_HI = 6;
	localparam int unsigned BITPOS_HI = 9;
	localparam int unsigned BITPOS_LO = 7;
	localparam int unsigned LIT8_HI = 7;
	localparam int unsigned LIT11_HI = 10;
	// Timing: last phase of the four-period instruction cycle
	localparam logic [1:0] PHASE_LAST = 2'h3;
	// Reset values
	localparam logic [13:0] WORD_RESET = 14'h0000;
	// Special file indexes
	localparam logic [6:0] FILE_TIMER0 = 7'h01;
	localparam logic [6:0] FILE_IP_LOW = 7'h02;
	localparam logic [6:0] FILE_PORT_A = 7'h05;
	localparam logic [6:0] FILE_PORT_LAST = 7'h09;

	typedef enum logic [1:0] {
		RID_GRP_BYTE,
		RID_GRP_BIT,
		RID_GRP_LIT
	} rid_group_e;

	typedef enum logic [4:0] {
		RID_NOP, RID_MOVWF, RID_CLR, RID_SUBWF, RID_DECF, RID_IORWF,
		RID_ANDWF, RID_XORWF, RID_ADDWF, RID_MOVF, RID_COMF, RID_INCF,
		RID_DECFSZ, RID_RRF, RID_RLF, RID_SWAPF, RID_INCFSZ,
		RID_BCF, RID_BSF, RID_BTFSC, RID_BTFSS,
		RID_CALL, RID_GOTO, RID_MOVLW, RID_RETLW, RID_IORLW, RID_ANDLW,
		RID_XORLW, RID_SUBLW, RID_ADDLW, RID_RET, RID_MISC
	} rid_op_e;

	typedef struct packed {
		rid_group_e group;
		rid_op_e op;
		logic to_file;
		logic [6:0] file_idx;
		logic [2:0] bit_pos;
		logic [7:0] lit8;
		logic [10:0] lit11;
		logic changes_ip;
		logic cond_test;
		logic writes_file;
		logic src_from_pins;
		logic clr_prescale;
	} rid_dec_s;
endpackage : rid_pkg

/* rtl/rid_field_split.sv */
// Combinational splitter: one 14-bit word into group, operation and fields.
// Assumes the word is stable for the cycle; no state inside.
`timescale 1ns/10ps
module rid_field_split
	import rid_pkg::*;
(
	// Instruction in
	input wire logic [13:0] word,
	// Decoded fields out
	output rid_dec_s dec
);
	// Byte-group opcode map, indexed by bits 11:8
	function automatic rid_op_e byte_op(input logic [3:0] c);
		unique case (c)
			4'h0: byte_op = RID_MOVWF;
			4'h1: byte_op = RID_CLR;
			4'h2: byte_op = RID_SUBWF;
			4'h3: byte_op = RID_DECF;
			4'h4: byte_op = RID_IORWF;
			4'h5: byte_op = RID_ANDWF;
			4'h6: byte_op = RID_XORWF;
			4'h7: byte_op = RID_ADDWF;
			4'h8: byte_op = RID_MOVF;
			4'h9: byte_op = RID_COMF;
			4'hA: byte_op = RID_INCF;
			4'hB: byte_op = RID_DECFSZ;
			4'hC: byte_op = RID_RRF;
			4'hD: byte_op = RID_RLF;
			4'hE: byte_op = RID_SWAPF;
			4'hF: byte_op = RID_INCFSZ;
		endcase
	endfunction : byte_op

	// Classification and field extraction; fields a group does not carry
	// stay zero; only the file_idx of NOP and RET still carries the don't-care bits 6:5
	always_comb begin
		dec = '0;
		unique case (word[OP_HI:OP_HI-1]) // RULE_01 RULE_02
			2'h0: begin
				dec.group = RID_GRP_BYTE;
				dec.op = byte_op(word[11:8]);
				dec.file_idx = word[FILE_HI:0]; // RULE_04 RULE_12
				dec.to_file = word[DEST_BIT]; // RULE_03 RULE_12
				if (word[11:8] == 4'h0 && !word[DEST_BIT]) begin
					// Don't-care bits 6:5 are masked out
					if (word[3:0] == 4'h8 || word[3:0] == 4'h9)
						dec.op = RID_RET; // RULE_07
					else if (word[4:0] == 5'h00)
						dec.op = RID_NOP; // RULE_07
					else
						dec.op = RID_MISC;
				end
			end
			2'h1: begin
				dec.group = RID_GRP_BIT;
				dec.file_idx = word[FILE_HI:0]; // RULE_04
				dec.bit_pos = word[BITPOS_HI:BITPOS_LO]; // RULE_05 RULE_12
				unique case (word[11:10])
					2'h0: dec.op = RID_BCF;
					2'h1: dec.op = RID_BSF;
					2'h2: dec.op = RID_BTFSC;
					2'h3: dec.op = RID_BTFSS;
				endcase
			end
			2'h2: begin
				dec.group = RID_GRP_LIT;
				dec.op = word[11] ? RID_GOTO : RID_CALL;
				dec.lit8 = word[LIT8_HI:0];
				dec.lit11 = word[LIT11_HI:0]; // RULE_06
			end
			2'h3: begin
				dec.group = RID_GRP_LIT;
				dec.lit8 = word[LIT8_HI:0]; // RULE_06
				// Bits marked don't care never steer the choice
				unique casez (word[11:8]) // RULE_07
					4'b00??: dec.op = RID_MOVLW;
					4'b01??: dec.op = RID_RETLW;
					4'b1000: dec.op = RID_IORLW;
					4'b1001: dec.op = RID_ANDLW;
					4'b1010: dec.op = RID_XORLW;
					4'b1011: dec.op = RID_MISC;
					4'b110?: dec.op = RID_SUBLW;
					4'b111?: dec.op = RID_ADDLW;
				endcase
			end
		endcase
	end
endmodule : rid_field_split

/* rtl/rid_decoder.sv */
// Top of the 14-bit instruction decoder with instruction-cycle sequencer.
// Assumes the fetch path presents a word each instruction cycle and the
// datapath returns the skip condition and prescaler assignment by phase 3.
// Overview of operation
// RULE_01: Each instruction is one 14-bit word split into opcode and operands.
// RULE_02: Words are sorted into byte, bit or literal/control groups.
// RULE_03: In byte operations a 0 destination bit targets the accumulator.
// RULE_04: The register index selects file registers 0x00 to 0x7F.
// RULE_05: In bit operations the bit position picks one bit of the register.
// RULE_06: Literal operations carry an 8-bit datum or an 11-bit target.
// RULE_07: Don't-care bit positions never change the decoded result; NOP and RET still pass bits 6:5 on in file_idx.
// RULE_08: One cycle per instruction, two when a skip hits or the pointer moves.
// RULE_09: Each instruction cycle spans exactly four clock periods.
// RULE_10: Read-modify-write of a port reads the pin levels, not the latch.
// RULE_11: Any write to the timer zero count clears its assigned prescaler.
// RULE_12: Opcode in 13:8, destination bit 7, index 6:0, bit position 9:7.
`timescale 1ns/10ps
module rid_decoder
	import rid_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fetch side
	input wire logic [13:0] fetch_word,
	output logic fetch_take,
	// Execute side feedback
	input wire logic skip_true,
	input wire logic prescale_on_timer,
	// Execute side outputs
	output rid_dec_s dec_out,
	output logic exec_valid,
	output logic flush_cycle,
	output logic [1:0] phase
);
	typedef enum logic [0:0] {
		RID_ST_EXEC,
		RID_ST_FLUSH
	} rid_state_e;

	rid_dec_s split;
	rid_dec_s dec_d, dec_q;
	rid_state_e state_d, state_q;
	logic [1:0] phase_d, phase_q;
	logic take_d, take_q;
	logic valid_d, valid_q;
	logic flush_d, flush_q;

	rid_field_split u_split (
		.word(fetch_word),
		.dec(split)
	);

	// True for any operation that stores into a file register; a clear
	// with the destination bit low only targets the accumulator
	function automatic logic file_write(input rid_dec_s d);
		file_write = (d.group == RID_GRP_BIT &&
			(d.op == RID_BCF || d.op == RID_BSF)) ||
			(d.group == RID_GRP_BYTE && d.to_file); // RULE_03
	endfunction : file_write

	// Sequencer: four phases per cycle, extra NOP cycle on branch or skip
	always_comb begin
		phase_d = phase_q + 2'h1; // RULE_09
		state_d = state_q;
		dec_d = dec_q;
		take_d = 1'b0;
		valid_d = valid_q;
		flush_d = flush_q;
		if (phase_q == PHASE_LAST) begin
			take_d = 1'b1;
			unique case (state_q)
				RID_ST_EXEC: begin
					// Decision on the word executed in this cycle
					if (dec_q.changes_ip || (dec_q.cond_test && skip_true))
						state_d = RID_ST_FLUSH; // RULE_08
				end
				RID_ST_FLUSH: state_d = RID_ST_EXEC;
			endcase
			if (state_d == RID_ST_FLUSH) begin
				dec_d = '0; // RULE_08
				dec_d.op = RID_NOP;
				valid_d = 1'b0;
				flush_d = 1'b1;
			end else begin
				dec_d = split;
				dec_d.changes_ip = split.op == RID_CALL ||
					split.op == RID_GOTO || split.op == RID_RETLW ||
					split.op == RID_RET ||
					(file_write(split) && split.file_idx == FILE_IP_LOW);
				dec_d.cond_test = split.op == RID_DECFSZ ||
					split.op == RID_INCFSZ || split.op == RID_BTFSC ||
					split.op == RID_BTFSS; // RULE_08
				dec_d.writes_file = file_write(split);
				// Port read-modify-write takes the pins as source
				dec_d.src_from_pins = file_write(split) &&
					split.op != RID_MOVWF && split.op != RID_CLR &&
					split.file_idx >= FILE_PORT_A &&
					split.file_idx <= FILE_PORT_LAST; // RULE_10
				// Prescaler assignment is sampled at phase 3 of decode
				dec_d.clr_prescale = file_write(split) &&
					split.file_idx == FILE_TIMER0 &&
					prescale_on_timer; // RULE_11
				valid_d = 1'b1;
				flush_d = 1'b0;
			end
		end
	end

	// Sequencer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= 2'h0;
			state_q <= RID_ST_EXEC;
			dec_q <= '0;
			take_q <= 1'b0;
			valid_q <= 1'b0;
			flush_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			state_q <= state_d;
			dec_q <= dec_d;
			take_q <= take_d;
			valid_q <= valid_d;
			flush_q <= flush_d;
		end
	end

	assign dec_out = dec_q;
	assign exec_valid = valid_q;
	assign flush_cycle = flush_q;
	assign phase = phase_q;
	assign fetch_take = take_q;
endmodule : rid_decoder

/* sim/rid_fetch_model.sv */
// Fetch path and datapath feedback model for the instruction decoder.
// Assumes the bench sets word and flags; values only hold in phase 3.
`timescale 1ns/10ps
module rid_fetch_model (
	// Phase from decoder
	input wire logic [1:0] phase,
	// Bench side
	input wire logic [13:0] w,
	input wire logic s,
	input wire logic p,
	// Decoder side
	output logic [13:0] fetch_word,
	output logic skip_true,
	output logic prescale_on_timer
);
	// Inverted outside phase 3, so a decoder sampling early sees junk
	assign fetch_word = (phase == 2'h3) ? w : ~w;
	assign skip_true = (phase == 2'h3) ? s : ~s;
	assign prescale_on_timer = (phase == 2'h3) ? p : ~p;
endmodule : rid_fetch_model

/* sim/rid_decoder_props.sv */
// Concurrent checks on the decoder ports, bound into rid_decoder.
// Assumes one clock domain with async active-low reset.
`timescale 1ns/10ps
module rid_decoder_props
	import rid_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched ports
	input wire logic [13:0] fetch_word,
	input wire logic fetch_take,
	input wire logic skip_true,
	input wire logic prescale_on_timer,
	input wire rid_dec_s dec_out,
	input wire logic exec_valid,
	input wire logic flush_cycle,
	input wire logic [1:0] phase
);
	logic [13:0] w_q;
	logic t_q;
	// Word and timer flag as seen at the previous edge
	always_ff @(posedge clk) begin
		w_q <= fetch_word;
		t_q <= prescale_on_timer;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_phase_step: assert property ($past(rst_n)
		|-> phase == $past(phase) + 2'h1)
		else $error("phase did not advance");
	a_take_edge: assert property (fetch_take |-> $past(phase) == 2'h3)
		else $error("fetch_take off the cycle boundary");
	a_dec_hold: assert property (phase != 2'h0 |-> $stable(dec_out))
		else $error("decode changed inside a cycle");
	a_byte_fields: assert property ($past(phase) == 2'h3 && exec_valid
		&& dec_out.group == RID_GRP_BYTE |-> dec_out.to_file == w_q[7]
		&& dec_out.file_idx == w_q[6:0]) else $error("byte fields wrong");
	a_bit_fields: assert property ($past(phase) == 2'h3 && exec_valid
		&& dec_out.group == RID_GRP_BIT |-> dec_out.bit_pos == w_q[9:7]
		&& dec_out.file_idx == w_q[6:0]) else $error("bit fields wrong");
	a_lit_fields: assert property ($past(phase) == 2'h3 && exec_valid
		&& dec_out.op >= RID_MOVLW && dec_out.op <= RID_ADDLW
		|-> dec_out.lit8 == w_q[7:0]) else $error("literal wrong");
	a_two_cycle: assert property (phase == 2'h3 && exec_valid
		&& (dec_out.changes_ip || dec_out.cond_test && skip_true)
		|=> flush_cycle && !exec_valid && dec_out.op == RID_NOP)
		else $error("no flush cycle");
	a_flush_len: assert property ($rose(flush_cycle)
		|-> flush_cycle[*4] ##1 !flush_cycle) else $error("flush length");
	a_timer_clear: assert property ($past(phase) == 2'h3 && exec_valid
		&& dec_out.writes_file && dec_out.file_idx == FILE_TIMER0
		|-> dec_out.clr_prescale == t_q) else $error("prescale clear wrong");
	c_flush: cover property ($rose(flush_cycle));
	c_bit: cover property (exec_valid && dec_out.group == RID_GRP_BIT);
	c_clr: cover property (dec_out.clr_prescale);
endmodule : rid_decoder_props

bind rid_decoder rid_decoder_props u_props (.clk(clk), .rst_n(rst_n),
	.fetch_word(fetch_word), .fetch_take(fetch_take),
	.skip_true(skip_true), .prescale_on_timer(prescale_on_timer),
	.dec_out(dec_out), .exec_valid(exec_valid),
	.flush_cycle(flush_cycle), .phase(phase));

/* sim/testbench.sv */
// Self-checking bench for the decoder with the fetch model in front.
// Assumes words are offered once per four-clock instruction cycle.
`timescale 1ns/10ps
module testbench
	import rid_pkg::*;
;
	logic clk, rst_n, s, p, skip_true, prescale_on_timer;
	logic fetch_take, exec_valid, flush_cycle;
	logic [13:0] w, fetch_word;
	logic [1:0] phase;
	rid_dec_s dec_out, save;
	int n_errors, n_tests;
	rid_fetch_model u_model (.phase(phase), .w(w), .s(s), .p(p),
		.fetch_word(fetch_word), .skip_true(skip_true),
		.prescale_on_timer(prescale_on_timer));
	rid_decoder dut (.clk(clk), .rst_n(rst_n), .fetch_word(fetch_word),
		.fetch_take(fetch_take), .skip_true(skip_true),
		.prescale_on_timer(prescale_on_timer), .dec_out(dec_out),
		.exec_valid(exec_valid), .flush_cycle(flush_cycle), .phase(phase));
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic stop_test;
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: %h expected %h", $time, g, e);
		end
	endtask : chk
	// Offer a word, wait until it is taken as a real instruction
	task automatic issue(input logic [13:0] wd, input logic sk);
		@(posedge clk);
		w <= wd;
		s <= sk;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			#1;
			if (fetch_take === 1'b1 && exec_valid === 1'b1) return;
		end
		n_errors++;
		stop_test();
	endtask : issue
	// Flush cycle expected one instruction cycle later
	task automatic flush_check;
		repeat (4) @(posedge clk);
		#1;
		chk(32'(flush_cycle), 1);
		chk(32'(exec_valid), 0);
	endtask : flush_check
	task automatic t_byte;
		issue(14'h07FF, 1'b0);
		chk(32'(dec_out.op), 32'(RID_ADDWF));
		chk(32'({dec_out.to_file, dec_out.file_idx}), 32'h0FF);
		issue(14'h0700, 1'b0);
		chk(32'({dec_out.to_file, dec_out.file_idx}), 32'h000);
	endtask : t_byte
	task automatic t_bit;
		issue(14'h1785, 1'b0);
		chk(32'(dec_out.group), 32'(RID_GRP_BIT));
		chk(32'({dec_out.bit_pos, dec_out.file_idx}), 32'h385);
	endtask : t_bit
	// Don't-care bits set must decode the same as cleared
	task automatic t_lit;
		issue(14'h30A5, 1'b0);
		save = dec_out;
		chk(32'({dec_out.op, dec_out.lit8}), 32'({RID_MOVLW, 8'hA5}));
		issue(14'h33A5, 1'b0);
		chk(32'(dec_out === save), 1);
	endtask : t_lit
	task automatic t_goto;
		issue(14'h2FFF, 1'b0);
		chk(32'(dec_out.lit11), 32'h7FF);
		flush_check();
	endtask : t_goto
	task automatic t_skip;
		issue(14'h1805, 1'b1);
		flush_check();
	endtask : t_skip
	// Mid-run reset: outputs cleared, first word taken at the 4th edge
	task automatic t_reset;
		int n;
		@(posedge clk);
		rst_n <= 1'b0;
		s <= 1'b0;
		@(posedge clk);
		#1;
		chk(32'({fetch_take, exec_valid, flush_cycle, phase}), 32'h0);
		chk(32'(dec_out === '0), 32'h1);
		@(posedge clk);
		rst_n <= 1'b1;
		w <= 14'h0700;
		n = 0;
		while (fetch_take !== 1'b1 && n < 16) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 16) begin
			n_errors++;
			stop_test();
		end
		chk(n, 32'h4);
		chk(32'(exec_valid), 32'h1);
	endtask : t_reset
	// Timer writes with and without prescaler, port writes with and without
	task automatic t_special;
		issue(14'h0081, 1'b0);
		chk(32'(dec_out.clr_prescale), 32'h0);
		@(posedge clk);
		p <= 1'b1;
		issue(14'h0081, 1'b0);
		chk(32'(dec_out.clr_prescale), 32'h1);
		issue(14'h0801, 1'b0);
		chk(32'(dec_out.clr_prescale), 32'h0);
		issue(14'h0101, 1'b0);
		chk(32'(dec_out.writes_file), 32'h0);
		issue(14'h0A85, 1'b0);
		chk(32'(dec_out.src_from_pins), 32'h1);
		issue(14'h0085, 1'b0);
		chk(32'(dec_out.src_from_pins), 32'h0);
	endtask : t_special
	// Main sequence
	initial begin
		rst_n = 1'b0;
		w = 14'h0000;
		s = 1'b0;
		p = 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_byte();
		t_bit();
		t_lit();
		t_goto();
		t_skip();
		t_reset();
		t_special();
		stop_test();
	end
endmodule : testbench
